// ---- hw/bus_fault_response.sv ----
// Purpose: Bus masters' reactions to errored write or read responses
// Assumes: One clock aclk, synchronous active-low reset, all inputs on aclk
// Notes:   Registers reached over AXI4-Lite; PCIe and packet DMA keep no state except dram_raw on a misaligned DRAM write
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "bus_fault_regs.svh"
module bus_fault_response (
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire logic [7:0]                 s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [7:0]                 s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   input  wire bus_fault_pkg::response_s   resp,
   input  wire logic                       link_active,
   input  wire logic                       dma_beat_in,
   output logic                            dma_beat_out,
   output logic [2:0]                      link_read_status,
   output logic                            core_fault_irq,
   output logic                            app_abort,
   output logic                            pcie_completion_abort,
   output logic                            dma_fault_irq,
   output logic [`NUM_CHAN-1:0]            channel_error_event,
   output logic [`NUM_CHAN-1:0]            rio_core_irq,
   output logic                            link_fault_interrupt,
   output logic                            dram_ecc_irq
);
   // Error test shared by every master except packet DMA
   function automatic logic is_error(input logic [2:0] st);
      is_error = (st != 3'h0);
   endfunction : is_error

   function automatic logic hit(input bus_fault_pkg::response_s r,
                                input bus_fault_pkg::source_e s);
      hit = r.valid && (r.source == s) && is_error(r.status);
   endfunction : hit

   bus_fault_pkg::axi_state_e   state;
   logic [7:0]                  waddr;
   logic [31:0]                 wdata;
   logic                        have_aw;
   logic                        have_w;
   logic                        core_valid;
   logic [2:0]                  core_kind;
   logic [31:0]                 core_addr;
   logic                        dma_valid;
   logic [2:0]                  dma_status;
   logic [31:0]                 dma_addr;
   logic [7:0]                  dma_master;
   logic                        dma_irq_en;
   logic                        dma_pending;
   logic                        abort_mask;
   logic                        abort_pending;
   logic [31:0]                 fault_addr;
   logic [7:0]                  fault_status;
   logic [`NUM_PRIV-1:0]        xlat_flags;
   logic [31:0]                 capt_first;
   logic [15:0]                 capt_second;
   logic [2*`NUM_PRIV-1:0]      routing;
   logic                        dram_raw;
   logic                        dram_en;
   logic [1:0]                  dram_core;
   logic [`NUM_CHAN-1:0]        chan_pending;
   logic [2:0]                  chan_code [`NUM_CHAN];
   logic                        link_pending;

   // Write decode; a write happens when both address and data are held
   wire        wr_go       = have_aw && have_w && (state == bus_fault_pkg::AX_IDLE);
   wire        wr_core     = wr_go && (waddr == `OFF_CORE_CAPTURE);
   wire        wr_dma      = wr_go && (waddr == `OFF_DMA_CTRL);
   wire        wr_abort    = wr_go && (waddr == `OFF_ABORT_CTRL);
   wire        wr_xlat     = wr_go && (waddr == `OFF_XLAT_FLAGS);
   wire        wr_route    = wr_go && (waddr == `OFF_ROUTING);
   wire        wr_raw      = wr_go && (waddr == `OFF_DRAM_RAW);
   wire        wr_en_set   = wr_go && (waddr == `OFF_DRAM_ENABLE_SET);
   wire        wr_en_clr   = wr_go && (waddr == `OFF_DRAM_ENABLE_CLR);
   wire        wr_clear    = wr_go && (waddr == `OFF_STATUS_CLEAR);
   wire        wr_known    = wr_core | wr_dma | wr_abort | wr_xlat | wr_route | wr_raw |
                             wr_en_set | wr_en_clr | wr_clear |
                             (waddr == `OFF_FAULT_DETAIL) | (waddr == `OFF_FAULT_ADDR) |
                             (waddr == `OFF_FAULT_STATUS) | (waddr == `OFF_CAPT_FIRST) |
                             (waddr == `OFF_CAPT_SECOND) | (waddr == `OFF_CHAN_QUEUE);
   wire        rd_go       = s_axi_arvalid && s_axi_arready;

   // Per-master hits
   wire        core_hit    = hit(resp, bus_fault_pkg::SRC_CORE);
   wire        app_hit     = hit(resp, bus_fault_pkg::SRC_APP);
   wire        pcie_rd_hit = hit(resp, bus_fault_pkg::SRC_PCIE) && resp.is_read;
   wire        dma_hit     = hit(resp, bus_fault_pkg::SRC_DMA);
   wire        ser_hit     = hit(resp, bus_fault_pkg::SRC_SER);
   wire        rio_hit     = hit(resp, bus_fault_pkg::SRC_RIO);
   wire        link_hit    = hit(resp, bus_fault_pkg::SRC_LINK);
   // Protected write that breaks 64-bit alignment or quanta
   wire        ecc_hit     = resp.valid && resp.dram_write && !resp.aligned;

   wire        clr_core    = wr_clear && wdata[0];
   wire        clr_dma     = wr_clear && wdata[1];
   wire        clr_abort   = wr_clear && wdata[2];
   wire        clr_link    = wr_clear && wdata[3];
   wire [3:0]  clr_chan    = wr_clear ? wdata[11:8] : 4'h0;

   wire [`NUM_PRIV-1:0] xlat_set = rio_hit ? (8'h01 << resp.priv) : 8'h00;
   wire [`NUM_PRIV-1:0] next_xlat = (xlat_flags & ~(wr_xlat ? wdata[7:0] : 8'h00))
                                    | xlat_set;

   // AXI4-Lite channel handshakes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= bus_fault_pkg::AX_IDLE;
         have_aw <= 1'b0;
         have_w <= 1'b0;
         waddr <= 8'h00;
         wdata <= 32'h0000_0000;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'h0;
         s_axi_rdata <= 32'h0000_0000;
      end else begin
         s_axi_awready <= !have_aw && !s_axi_awready && (state == bus_fault_pkg::AX_IDLE);
         s_axi_wready <= !have_w && !s_axi_wready && (state == bus_fault_pkg::AX_IDLE);
         s_axi_arready <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            have_aw <= 1'b1;
            waddr <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            have_w <= 1'b1;
            wdata <= s_axi_wdata;
         end
         case (state)
            bus_fault_pkg::AX_IDLE: begin
               if (wr_go) begin
                  have_aw <= 1'b0;
                  have_w <= 1'b0;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_DECERR;
                  state <= bus_fault_pkg::AX_WRESP;
               end else if (s_axi_arvalid && !have_aw && !have_w) begin
                  s_axi_arready <= 1'b1;
                  state <= bus_fault_pkg::AX_RDATA;
               end
            end
            bus_fault_pkg::AX_WRESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  state <= bus_fault_pkg::AX_IDLE;
               end
            end
            bus_fault_pkg::AX_RDATA: begin
               if (rd_go) begin
                  s_axi_rvalid <= 1'b1;
                  s_axi_rresp <= `RESP_OKAY;
                  case ({s_axi_araddr[7:2], 2'b00})
                     `OFF_CORE_CAPTURE:    s_axi_rdata <= {28'h0, core_kind, core_valid};
                     `OFF_FAULT_DETAIL:    s_axi_rdata <= {dma_master, 20'h0, dma_status,
                                                           dma_valid};
                     `OFF_DMA_CTRL:        s_axi_rdata <= {31'h0, dma_irq_en};
                     `OFF_ABORT_CTRL:      s_axi_rdata <= {31'h0, abort_mask};
                     `OFF_FAULT_ADDR:      s_axi_rdata <= fault_addr;
                     `OFF_FAULT_STATUS:    s_axi_rdata <= {24'h0, fault_status};
                     `OFF_XLAT_FLAGS:      s_axi_rdata <= {24'h0, xlat_flags};
                     `OFF_CAPT_FIRST:      s_axi_rdata <= capt_first;
                     `OFF_CAPT_SECOND:     s_axi_rdata <= {16'h0, capt_second};
                     `OFF_ROUTING:         s_axi_rdata <= {16'h0, routing};
                     `OFF_DRAM_RAW:        s_axi_rdata <= {31'h0, dram_raw};
                     `OFF_DRAM_ENABLE_SET: s_axi_rdata <= {29'h0, dram_core, dram_en};
                     `OFF_DRAM_ENABLE_CLR: s_axi_rdata <= {31'h0, dram_en};
                     `OFF_CHAN_QUEUE:      s_axi_rdata <= {16'h0, chan_code[3], chan_code[2],
                                                           chan_code[1], chan_code[0],
                                                           chan_pending};
                     `OFF_STATUS_CLEAR:    s_axi_rdata <= 32'h0000_0000;
                     default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `RESP_DECERR;
                     end
                  endcase
               end else if (s_axi_rvalid && s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  state <= bus_fault_pkg::AX_IDLE;
               end
            end
            default: state <= bus_fault_pkg::AX_IDLE;
         endcase
      end
   end

   // Core port and application core
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_valid <= 1'b0;
         core_kind <= 3'h0;
         core_addr <= 32'h0000_0000;
         abort_mask <= `ABORT_MASK_RESET;
         abort_pending <= 1'b0;
         fault_addr <= 32'h0000_0000;
         fault_status <= 8'h00;
      end else begin
         // Set beats clear, so a fault in the clear cycle survives
         if (core_hit && (!core_valid || clr_core || wr_core)) begin
            core_valid <= 1'b1;
            core_kind <= `CORE_FAULT_KIND;
            core_addr <= resp.addr;
         end else if (clr_core || wr_core) begin
            core_valid <= 1'b0;
         end
         if (wr_abort) begin
            abort_mask <= wdata[0];
         end
         if (app_hit) begin
            abort_pending <= 1'b1;
            fault_status <= {resp.sync, resp.is_read, 3'h0, resp.status};
            if (resp.sync) begin
               fault_addr <= resp.addr;
            end
         end else if (clr_abort) begin
            abort_pending <= 1'b0;
         end
      end
   end

   // DMA controller, RapidIO, serial channels, link, DRAM
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dma_valid <= 1'b0;
         dma_status <= 3'h0;
         dma_addr <= 32'h0000_0000;
         dma_master <= 8'h00;
         dma_irq_en <= `DMA_IRQ_EN_RESET;
         dma_pending <= 1'b0;
         xlat_flags <= 8'h00;
         capt_first <= 32'h0000_0000;
         capt_second <= 16'h0000;
         routing <= 16'h0000;
         dram_raw <= 1'b0;
         dram_en <= 1'b0;
         dram_core <= 2'h0;
         chan_pending <= 4'h0;
         link_pending <= 1'b0;
         for (int i = 0; i < `NUM_CHAN; i++) begin
            chan_code[i] <= 3'h0;
         end
      end else begin
         if (dma_hit) begin
            dma_valid <= 1'b1;
            dma_status <= resp.status;
            dma_addr <= resp.addr;
            dma_master <= resp.master;
            dma_pending <= 1'b1;
         end else if (clr_dma) begin
            dma_valid <= 1'b0;
            dma_pending <= 1'b0;
         end
         if (wr_dma) begin
            dma_irq_en <= wdata[0];
         end
         xlat_flags <= next_xlat;
         if (rio_hit && !resp.posted) begin
            capt_first <= resp.addr;
            capt_second <= {resp.master, 5'h00, resp.priv};
         end
         if (wr_route) begin
            routing <= wdata[15:0];
         end
         // Write ECC flag, set wins over clear
         if (ecc_hit) begin
            dram_raw <= 1'b1;
         end else if (wr_raw && wdata[0]) begin
            dram_raw <= 1'b0;
         end
         if (wr_en_set) begin
            dram_en <= dram_en | wdata[0];
            dram_core <= wdata[2:1];
         end else if (wr_en_clr && wdata[0]) begin
            dram_en <= 1'b0;
         end
         for (int i = 0; i < `NUM_CHAN; i++) begin
            if (ser_hit && (resp.chan == i[1:0])) begin
               chan_pending[i] <= 1'b1;
               chan_code[i] <= resp.status;
            end else if (clr_chan[i]) begin
               chan_pending[i] <= 1'b0;
            end
         end
         if (link_hit) begin
            link_pending <= 1'b1;
         end else if (clr_link) begin
            link_pending <= 1'b0;
         end
      end
   end

   // Registered outputs toward cores and requesters
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_fault_irq <= 1'b0;
         app_abort <= 1'b0;
         pcie_completion_abort <= 1'b0;
         dma_fault_irq <= 1'b0;
         channel_error_event <= 4'h0;
         rio_core_irq <= 4'h0;
         link_fault_interrupt <= 1'b0;
         link_read_status <= 3'h0;
         dram_ecc_irq <= 1'b0;
         dma_beat_out <= 1'b0;
      end else begin
         core_fault_irq <= core_valid;
         app_abort <= abort_pending && !abort_mask;
         // PCIe has no log and no irq; write errors answer nothing
         pcie_completion_abort <= pcie_rd_hit;
         dma_fault_irq <= dma_pending && dma_irq_en;
         channel_error_event <= chan_pending;
         for (int c = 0; c < `NUM_CHAN; c++) begin
            rio_core_irq[c] <= 1'b0;
            for (int p = 0; p < `NUM_PRIV; p++) begin
               if (xlat_flags[p] && (routing[2*p +: 2] == c[1:0])) begin
                  rio_core_irq[c] <= 1'b1;
               end
            end
         end
         link_fault_interrupt <= link_pending;
         if (link_active && resp.valid && resp.is_read &&
             resp.source == bus_fault_pkg::SRC_LINK) begin
            link_read_status <= resp.status;
         end
         // One ECC line; dram_core is stored for readback but steers nothing
         dram_ecc_irq <= dram_raw && dram_en;
         // Data beats pass regardless of any fault
         dma_beat_out <= dma_beat_in;
      end
   end
   // Packet DMA responses touch no state except dram_raw on a misaligned DRAM write

endmodule : bus_fault_response

// ---- hw/bus_fault_regs.svh ----
// Purpose: Offsets, fields and reset values for the bus fault response block
// Assumes: AXI4-Lite slave, 32-bit data, one aligned word per register
// Notes:   Included by the package and the design
`ifndef BUS_FAULT_REGS_SVH
`define BUS_FAULT_REGS_SVH
`define OFF_CORE_CAPTURE     8'h00
`define OFF_FAULT_DETAIL     8'h04
`define OFF_DMA_CTRL         8'h08
`define OFF_ABORT_CTRL       8'h0C
`define OFF_FAULT_ADDR       8'h10
`define OFF_FAULT_STATUS     8'h14
`define OFF_XLAT_FLAGS       8'h18
`define OFF_CAPT_FIRST       8'h1C
`define OFF_CAPT_SECOND      8'h20
`define OFF_ROUTING          8'h24
`define OFF_DRAM_RAW         8'h28
`define OFF_DRAM_ENABLE_SET  8'h2C
`define OFF_DRAM_ENABLE_CLR  8'h30
`define OFF_CHAN_QUEUE       8'h34
`define OFF_STATUS_CLEAR     8'h38
`define CORE_FAULT_KIND      3'h4
`define ABORT_MASK_RESET     1'b1
`define DMA_IRQ_EN_RESET     1'b0
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2
`define RESP_DECERR          2'h3
`define NUM_CHAN             4
`define NUM_PRIV             8
`endif

// ---- hw/bus_fault_pkg.sv ----
// Purpose: Types shared by the bus fault response block
// Assumes: Constants come from bus_fault_regs.svh
// Notes:   Carriers are packed structs
`include "bus_fault_regs.svh"
package bus_fault_pkg;
   // Master that issued the transfer whose response is returned
   typedef enum logic [7:0] {
      SRC_CORE  = 8'h01,
      SRC_APP   = 8'h02,
      SRC_PCIE  = 8'h04,
      SRC_DMA   = 8'h08,
      SRC_PKT   = 8'h10,
      SRC_SER   = 8'h20,
      SRC_RIO   = 8'h40,
      SRC_LINK  = 8'h80
   } source_e;
   typedef struct packed {
      logic          valid;
      logic          is_read;
      logic [2:0]    status;
      logic [31:0]   addr;
      logic [2:0]    priv;
      logic [7:0]    master;
      logic          posted;
      logic [1:0]    chan;
      logic          sync;
      logic          dram_write;
      logic          aligned;
      source_e       source;
   } response_s;
   typedef enum logic [2:0] {
      AX_IDLE  = 3'b001,
      AX_WRESP = 3'b010,
      AX_RDATA = 3'b100
   } axi_state_e;
endpackage : bus_fault_pkg

// ---- verification/bus_fault_response_chk.sv ----
// Purpose: Port-level assertions for the bus fault response block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to the top module; sees its ports only
`timescale 1ns/1ps
module bus_fault_response_chk (
   input wire logic                     aclk,
   input wire logic                     aresetn,
   input wire logic                     s_axi_bvalid,
   input wire bus_fault_pkg::response_s resp,
   input wire logic                     link_active,
   input wire logic                     dma_beat_in,
   input wire logic                     dma_beat_out,
   input wire logic [2:0]               link_read_status,
   input wire logic                     core_fault_irq,
   input wire logic                     pcie_completion_abort,
   input wire logic [3:0]               channel_error_event,
   input wire logic                     link_fault_interrupt
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire logic err      = resp.valid && resp.status != 3'h0;
   wire logic core_err = err && resp.source == bus_fault_pkg::SRC_CORE;
   wire logic pcie_rd  = err && resp.is_read && resp.source == bus_fault_pkg::SRC_PCIE;
   wire logic ser_err  = err && resp.source == bus_fault_pkg::SRC_SER;
   wire logic link_err = err && link_active && resp.source == bus_fault_pkg::SRC_LINK;
   wire logic link_rd  = resp.valid && resp.is_read && link_active
                         && resp.source == bus_fault_pkg::SRC_LINK;
   property chan_evt;
      logic [1:0] c;
      (ser_err, c = resp.chan) |-> ##2 channel_error_event[c];
   endproperty
   property link_pass;
      logic [2:0] s;
      (link_rd, s = resp.status) |-> ##1 link_read_status == s;
   endproperty
   AST_CORE_IRQ: assert property (core_err |-> ##2 core_fault_irq)
      else $error("core error not flagged");
   AST_CORE_HOLD: assert property ($fell(core_fault_irq) |-> $past(s_axi_bvalid))
      else $error("core capture lost");
   AST_PCIE_RD: assert property (pcie_rd |-> ##[1:2] pcie_completion_abort)
      else $error("pcie read abort missing");
   AST_PCIE_ONLY: assert property (pcie_completion_abort |-> $past(pcie_rd)
      || $past(pcie_rd, 2)) else $error("stray pcie abort");
   AST_DMA_FLOW: assert property ($past(aresetn) |->
      dma_beat_out == $past(dma_beat_in)) else $error("dma data not passed on");
   AST_CHAN_EVT: assert property (chan_evt) else $error("channel event missing");
   AST_LINK_STATUS: assert property (link_pass) else $error("link status altered");
   AST_LINK_IRQ: assert property (link_err |-> ##2 link_fault_interrupt)
      else $error("link irq missing");
   COV_CORE: cover property (core_err ##2 core_fault_irq);
   COV_PCIE: cover property (pcie_completion_abort);
   COV_CHAN: cover property ($rose(channel_error_event[3]));
endmodule : bus_fault_response_chk
bind bus_fault_response bus_fault_response_chk u_chk (.aclk, .aresetn, .s_axi_bvalid, .resp,
   .link_active, .dma_beat_in, .dma_beat_out, .link_read_status, .core_fault_irq,
   .pcie_completion_abort, .channel_error_event, .link_fault_interrupt);

// ---- verification/mem_slave_model.sv ----
// Purpose: Memory-system slave answering a master's transfer with a status
// Assumes: One request at a time, answered lag+1 cycles after it is taken
// Notes:   Idle fields toggle so the block cannot lean on stale values
`timescale 1ns/1ps
module mem_slave_model (
   input  wire logic                     aclk,
   input  wire logic                     req_valid,
   input  wire bus_fault_pkg::response_s req,
   input  wire logic [3:0]               lag,
   output bus_fault_pkg::response_s      resp
);
   bus_fault_pkg::response_s held;
   logic [3:0]               wait_cnt;
   logic                     pending;
   initial begin
      resp = '0;
      pending = 1'b0;
   end
   always @(posedge aclk) begin
      if (req_valid) begin
         held <= req;
         wait_cnt <= lag;
         pending <= 1'b1;
      end
      if (pending && wait_cnt == 4'h0) begin
         resp <= held;
         resp.valid <= 1'b1;
         pending <= 1'b0;
      end else begin
         if (pending) wait_cnt <= wait_cnt - 4'h1;
         resp <= {1'b0, ~resp[$bits(bus_fault_pkg::response_s)-2:0]};
      end
   end
endmodule : mem_slave_model

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench for the bus fault response block
// Assumes: Register offsets as the block defines them
// Notes:   Table rows for single responses, hand tests for the rest
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {
      bus_fault_pkg::source_e src;
      logic rd;
      logic [2:0] st;
      logic [1:0] ch;
      logic [3:0] ev;
      logic [2:0] cla;
   } row_s;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, lag, channel_error_event, rio_core_irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [2:0] link_read_status;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, req_valid;
   logic link_active, dma_beat_in, dma_beat_out, core_fault_irq, app_abort, saw_ab;
   logic pcie_completion_abort, dma_fault_irq, link_fault_interrupt, dram_ecc_irq;
   bus_fault_pkg::response_s req, resp, r;
   int num_errors, checked;
   row_s w;
   // Expected {core irq, link irq, pcie abort}
   row_s rows [9] = '{'{bus_fault_pkg::SRC_CORE, 1'b0, 3'h2, 2'h0, 4'h0, 3'b100},
      '{bus_fault_pkg::SRC_CORE, 1'b1, 3'h0, 2'h0, 4'h0, 3'b000},
      '{bus_fault_pkg::SRC_PCIE, 1'b1, 3'h2, 2'h0, 4'h0, 3'b001},
      '{bus_fault_pkg::SRC_PCIE, 1'b0, 3'h3, 2'h0, 4'h0, 3'b000},
      '{bus_fault_pkg::SRC_DMA, 1'b0, 3'h2, 2'h0, 4'h0, 3'b000},
      '{bus_fault_pkg::SRC_PKT, 1'b1, 3'h2, 2'h0, 4'h0, 3'b000},
      '{bus_fault_pkg::SRC_APP, 1'b1, 3'h2, 2'h0, 4'h0, 3'b000},
      '{bus_fault_pkg::SRC_SER, 1'b0, 3'h1, 2'h2, 4'h4, 3'b000},
      '{bus_fault_pkg::SRC_LINK, 1'b1, 3'h6, 2'h0, 4'h0, 3'b010}};
   mem_slave_model u_slave (.aclk, .req_valid, .req, .lag, .resp);
   bus_fault_response dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .resp, .link_active, .dma_beat_in, .dma_beat_out,
      .link_read_status, .core_fault_irq, .app_abort, .pcie_completion_abort, .dma_fault_irq,
      .channel_error_event, .rio_core_irq, .link_fault_interrupt, .dram_ecc_irq);
   always #5 aclk = ~aclk;
   // Sticky copy of a one-cycle pulse
   always @(posedge aclk) if (pcie_completion_abort) saw_ab <= 1'b1;
   task automatic give_verdict;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      int n;
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
      for (n = 0; n < 40 && !(n > 0 && s_axi_bvalid); n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      chk({n < 40, s_axi_bresp}, {1'b1, (a == 8'h3C) ? 2'h3 : 2'h0});
      if (n == 40) give_verdict();
      @(posedge aclk);
   endtask : axw
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                        input logic [1:0] er);
      int n;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
      for (n = 0; n < 40 && !(n > 0 && s_axi_rvalid); n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      chk(n < 40, 1'b1);
      if (n == 40) give_verdict();
      chk(s_axi_rdata & m, e);
      chk(s_axi_rresp, er);
      @(posedge aclk);
   endtask : rdchk
   task automatic hit(input bus_fault_pkg::response_s x, input logic [3:0] l);
      {req, req_valid, lag, dma_beat_in} <= {x, 1'b1, l, ~dma_beat_in};
      @(posedge aclk);
      req_valid <= 1'b0;
      repeat (int'(l) + 5) @(posedge aclk);
   endtask : hit
   function automatic bus_fault_pkg::response_s mk(input bus_fault_pkg::source_e s,
         input logic rd, input logic [2:0] st, input logic [1:0] ch);
      mk = '{1'b1, rd, st, 32'h0000_1A40, 3'h5, 8'h2C, 1'b0, ch, 1'b1, 1'b0, 1'b1, s};
   endfunction : mk
   initial begin
      {aclk, aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready, req, req_valid, lag, dma_beat_in, saw_ab} = '0;
      {s_axi_wstrb, link_active, num_errors, checked} = {5'h1F, 64'h0};
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rdchk(8'h0C, 32'h0000_0001, 32'h0000_0001, 2'h0);
      foreach (rows[i]) begin
         w = rows[i];
         saw_ab <= 1'b0;
         hit(mk(w.src, w.rd, w.st, w.ch), 4'(i % 3));
         chk({core_fault_irq, link_fault_interrupt, saw_ab}, w.cla);
         chk(channel_error_event, w.ev);
         chk({dma_fault_irq, app_abort, rio_core_irq}, 6'h00);
         if (w.src == bus_fault_pkg::SRC_LINK) chk(link_read_status, w.st);
         axw(8'h38, 32'h0000_0F0F);
      end
      hit(mk(bus_fault_pkg::SRC_SER, 1'b0, 3'h5, 2'h3), 4'h2);
      chk(channel_error_event, 4'h8);
      rdchk(8'h34, 32'h0000_A408, 32'h0000_FFFF, 2'h0);
      r = mk(bus_fault_pkg::SRC_CORE, 1'b0, 3'h2, 2'h0);
      r.dram_write = 1'b1;
      r.aligned = 1'b0;
      hit(r, 4'h9);
      rdchk(8'h00, 32'h0000_0009, 32'h0000_000F, 2'h0);
      rdchk(8'h28, 32'h0000_0001, 32'h0000_0001, 2'h0);
      chk(dram_ecc_irq, 1'b0);
      axw(8'h2C, 32'h0000_0001);
      chk(dram_ecc_irq, 1'b1);
      axw(8'h28, 32'h0000_0001);
      axw(8'h38, 32'h0000_0001);
      r.aligned = 1'b1;
      hit(r, 4'h0);
      rdchk(8'h28, 32'h0000_0000, 32'h0000_0001, 2'h0);
      chk({core_fault_irq, dram_ecc_irq}, 2'b10);
      axw(8'h08, 32'h0000_0001);
      hit(mk(bus_fault_pkg::SRC_DMA, 1'b1, 3'h3, 2'h0), 4'h0);
      chk(dma_fault_irq, 1'b1);
      rdchk(8'h04, 32'h2C00_0007, 32'hFF00_000F, 2'h0);
      axw(8'h0C, 32'h0000_0000);
      hit(mk(bus_fault_pkg::SRC_APP, 1'b1, 3'h2, 2'h0), 4'h1);
      chk(app_abort, 1'b1);
      rdchk(8'h10, 32'h0000_1A40, 32'hFFFF_FFFF, 2'h0);
      rdchk(8'h14, 32'h0000_00C2, 32'h0000_00C7, 2'h0);
      axw(8'h24, 32'h0000_0800);
      hit(mk(bus_fault_pkg::SRC_RIO, 1'b1, 3'h2, 2'h0), 4'h1);
      rdchk(8'h18, 32'h0000_0020, 32'h0000_00FF, 2'h0);
      chk(rio_core_irq, 4'h4);
      rdchk(8'h1C, 32'h0000_1A40, 32'hFFFF_FFFF, 2'h0);
      rdchk(8'h20, 32'h0000_2C05, 32'h0000_FF07, 2'h0);
      axw(8'h3C, 32'h0000_0000);
      rdchk(8'h3C, 32'h0000_0000, 32'h0000_0000, 2'h3);
      // Mid-run reset must drop the core, abort, DMA and RapidIO flags and re-mask the abort
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk({core_fault_irq, app_abort, dma_fault_irq, rio_core_irq}, 7'h00);
      rdchk(8'h0C, 32'h0000_0001, 32'h0000_0001, 2'h0);
      give_verdict();
   end
endmodule : tb_top
